// ### pkg/lhr_pkg.sv
package lhr_pkg;
   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int          CLK_MHZ          = 250;
   localparam int          RELOCK_MS        = 100;
   localparam int          RELOCK_CYC       = RELOCK_MS * CLK_MHZ * 1000;
   localparam int          HOLD_LEAD_MS     = 2;
   localparam int          HOLD_LEAD_CYC    = HOLD_LEAD_MS * CLK_MHZ * 1000;
   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0]  ADR_CTRL         = 8'h00;
   localparam logic [7:0]  ADR_STAT         = 8'h04;
   localparam logic [7:0]  ADR_DRIFT        = 8'h08;
   localparam logic [7:0]  ADR_EDIT         = 8'h0C;
   localparam logic [7:0]  ADR_FILT         = 8'h10;
   localparam logic [7:0]  ADR_GAIN         = 8'h14;
   localparam logic [7:0]  ADR_TIME         = 8'h18;
   localparam logic [7:0]  ADR_ERR          = 8'h1C;
   localparam logic [7:0]  ADR_OUT          = 8'h20;
   // ------------------------------------------------------------------
   // Control, status and edit fields
   // ------------------------------------------------------------------
   localparam int          CTRL_LOCK        = 0;
   localparam int          CTRL_SWEEP       = 1;
   localparam int          CTRL_NEGPOL      = 2;
   localparam int          CTRL_PRESET_LO   = 4;
   localparam int          CTRL_PRESET_HI   = 6;
   localparam int          CTRL_PRESET_GO   = 7;
   localparam int          STAT_HOLD        = 0;
   localparam int          STAT_READY       = 1;
   localparam int          STAT_RELOCK      = 2;
   localparam int          STAT_CFG_REJ     = 3;
   localparam int          STAT_EDITING     = 4;
   localparam int          EDIT_KEY_COMMIT  = 16;
   localparam int          EDIT_KEY_DISCARD = 17;
   localparam int          EDIT_SEL_LO      = 18;
   localparam int          EDIT_SEL_HI      = 19;
   // ------------------------------------------------------------------
   // Parameter triples: filter Hz, gain in 0.1 dB, time in ms
   // ------------------------------------------------------------------
   localparam logic [15:0] DEF_FILT         = 16'h00c8;  // 200 Hz
   localparam logic [15:0] DEF_GAIN         = 16'hfec0;  // -32.0 dB
   localparam logic [15:0] DEF_TIME         = 16'h0088;  // 136 ms
   localparam logic [15:0] ANA_FILT         = 16'h07ee;  // 2030 Hz
   localparam logic [15:0] HB1_FILT         = 16'h03e8;  // 1000 Hz
   localparam logic [15:0] HB1_GAIN         = 16'h0084;  // 13.2 dB
   localparam logic [15:0] HB1_TIME         = 16'h003b;  // 59 ms
   localparam logic [15:0] HB2_FILT         = 16'h05dc;  // 1500 Hz
   localparam logic [15:0] HB2_GAIN         = 16'h0098;  // 15.2 dB
   localparam logic [15:0] HB2_TIME         = 16'h002f;  // 47 ms
   localparam logic [15:0] HB3_FILT         = 16'h07d0;  // 2000 Hz
   localparam logic [15:0] HB3_GAIN         = 16'h00a8;  // 16.8 dB
   localparam logic [15:0] HB3_TIME         = 16'h0029;  // 41 ms
   localparam logic [2:0]  PRE_DEFAULT      = 3'h0;
   localparam logic [2:0]  PRE_ANALOG       = 3'h1;
   localparam logic [2:0]  PRE_HB1          = 3'h2;
   localparam logic [2:0]  PRE_HB2          = 3'h3;
   localparam logic [2:0]  PRE_HB3          = 3'h4;
   localparam logic [1:0]  SEL_FILT         = 2'h0;
   localparam logic [1:0]  SEL_GAIN         = 2'h1;
   localparam logic [1:0]  SEL_TIME         = 2'h2;
   localparam logic [1:0]  SEL_DRIFT        = 2'h3;
endpackage : lhr_pkg

// ### pkg/lhr_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lhr_link_if;
   logic holdReq;
   logic readyLed;
   modport regulator (input holdReq, output readyLed);
   modport timing    (output holdReq, input readyLed);
endinterface : lhr_link_if
`default_nettype wire

// ### logic/lhr_regulator.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module lhr_regulator #(
   parameter int RELOCK_CYC = lhr_pkg::RELOCK_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Link
   lhr_link_if.regulator    link,
   // Wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatW,
   output logic      [31:0] wbDatR,
   output logic             wbAck,
   // Regulator
   input  wire logic [15:0] lockErr,
   output logic      [15:0] regOut
);
   if (RELOCK_CYC < 1)
   begin : g_badRelock
      $error("RELOCK_CYC must be positive");
   end

   // ------------------------------------------------------------------
   // Hold input synchroniser and polarity
   // ------------------------------------------------------------------
   logic        holdS1_r, holdS2_r, hold_r, negPol_r, ready_r, relock_r, cfgRej_r;
   logic [31:0] relockCnt_r;
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
      begin
         holdS1_r <= 1'b0;
         holdS2_r <= 1'b0;
      end
      else
      begin
         holdS1_r <= link.holdReq;
         holdS2_r <= holdS1_r;
      end

   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         hold_r <= 1'b0;
      else
         hold_r <= holdS2_r ^ negPol_r;

   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         ready_r <= 1'b0;
      else
         ready_r <= !(holdS2_r ^ negPol_r);
   assign link.readyLed = ready_r;

   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
      begin
         relock_r    <= 1'b0;
         relockCnt_r <= '0;
      end
      else if (hold_r)
      begin
         relock_r    <= 1'b1;
         relockCnt_r <= 32'(RELOCK_CYC);
      end
      else if (relockCnt_r != 0)
         relockCnt_r <= relockCnt_r - 32'd1;
      else
         relock_r    <= 1'b0;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic        lockOn_r, sweepOn_r, editing_r;
   logic [1:0]  editSel_r;
   logic [15:0] filt_r, gain_r, time_r, drift_r, editVal_r;
   logic        wrHit;
   assign wrHit = wbCyc && wbStb && wbWe && !wbAck;

   function automatic logic [47:0] preset(input logic [2:0] p);
      case (p)
         lhr_pkg::PRE_ANALOG: preset = {lhr_pkg::ANA_FILT, lhr_pkg::DEF_GAIN,
                                        lhr_pkg::DEF_TIME};
         lhr_pkg::PRE_HB1:    preset = {lhr_pkg::HB1_FILT, lhr_pkg::HB1_GAIN,
                                        lhr_pkg::HB1_TIME};
         lhr_pkg::PRE_HB2:    preset = {lhr_pkg::HB2_FILT, lhr_pkg::HB2_GAIN,
                                        lhr_pkg::HB2_TIME};
         lhr_pkg::PRE_HB3:    preset = {lhr_pkg::HB3_FILT, lhr_pkg::HB3_GAIN,
                                        lhr_pkg::HB3_TIME};
         default:             preset = {lhr_pkg::DEF_FILT, lhr_pkg::DEF_GAIN,
                                        lhr_pkg::DEF_TIME};
      endcase
   endfunction : preset

   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
      begin
         lockOn_r  <= 1'b0;
         sweepOn_r <= 1'b0;
         negPol_r  <= 1'b0;
         cfgRej_r  <= 1'b0;
      end
      else if (wrHit && wbAdr == lhr_pkg::ADR_CTRL && wbSel[0])
      begin
         lockOn_r  <= wbDatW[lhr_pkg::CTRL_LOCK];
         sweepOn_r <= wbDatW[lhr_pkg::CTRL_SWEEP];
         if (hold_r && wbDatW[lhr_pkg::CTRL_NEGPOL] != negPol_r)
            cfgRej_r <= 1'b1;
         else if (!hold_r)
         begin
            negPol_r <= wbDatW[lhr_pkg::CTRL_NEGPOL];
            cfgRej_r <= 1'b0;
         end
      end

   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
      begin
         filt_r    <= lhr_pkg::DEF_FILT;
         gain_r    <= lhr_pkg::DEF_GAIN;
         time_r    <= lhr_pkg::DEF_TIME;
         drift_r   <= '0;
         editVal_r <= '0;
         editSel_r <= lhr_pkg::SEL_FILT;
         editing_r <= 1'b0;
      end
      else if (wrHit && wbAdr == lhr_pkg::ADR_CTRL && wbSel[0]
               && wbDatW[lhr_pkg::CTRL_PRESET_GO])
         {filt_r, gain_r, time_r} <=
            preset(wbDatW[lhr_pkg::CTRL_PRESET_HI:lhr_pkg::CTRL_PRESET_LO]);
      else if (wrHit && wbAdr == lhr_pkg::ADR_EDIT)
      begin
         if (wbDatW[lhr_pkg::EDIT_KEY_COMMIT] && editing_r)
         begin
            editing_r <= 1'b0;
            case (editSel_r)
               lhr_pkg::SEL_FILT: filt_r  <= editVal_r;
               lhr_pkg::SEL_GAIN: gain_r  <= editVal_r;
               lhr_pkg::SEL_TIME: time_r  <= editVal_r;
               default:           drift_r <= editVal_r;
            endcase
         end
         else if (wbDatW[lhr_pkg::EDIT_KEY_DISCARD])
            editing_r <= 1'b0;
         else
         begin
            editing_r <= 1'b1;
            editVal_r <= wbDatW[15:0];
            editSel_r <= wbDatW[lhr_pkg::EDIT_SEL_HI:lhr_pkg::EDIT_SEL_LO];
         end
      end

   // ------------------------------------------------------------------
   // Regulator: integrator of scaled error, frozen in hold
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         regOut <= '0;
      else if (hold_r)
         regOut <= regOut;
      else if (lockOn_r)
         regOut <= regOut + 16'(($signed(lockErr) >>> 4));
      else if (!sweepOn_r && drift_r != 0)
         regOut <= regOut + drift_r;

   // ------------------------------------------------------------------
   // Wishbone read and ack
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
      begin
         wbAck  <= 1'b0;
         wbDatR <= '0;
      end
      else
      begin
         wbAck  <= wbCyc && wbStb && !wbAck;
         case (wbAdr)
            lhr_pkg::ADR_CTRL:  wbDatR <= {29'd0, negPol_r, sweepOn_r, lockOn_r};
            lhr_pkg::ADR_STAT:  wbDatR <= {27'd0, editing_r, cfgRej_r, relock_r,
                                           ready_r, hold_r};
            lhr_pkg::ADR_DRIFT: wbDatR <= {16'd0, drift_r};
            lhr_pkg::ADR_EDIT:  wbDatR <= {12'd0, editSel_r, 2'd0, editVal_r};
            lhr_pkg::ADR_FILT:  wbDatR <= {16'd0, filt_r};
            lhr_pkg::ADR_GAIN:  wbDatR <= {16'd0, gain_r};
            lhr_pkg::ADR_TIME:  wbDatR <= {16'd0, time_r};
            lhr_pkg::ADR_ERR:   wbDatR <= {16'd0, lockErr};
            lhr_pkg::ADR_OUT:   wbDatR <= {16'd0, regOut};
            default:            wbDatR <= '0;
         endcase
      end
endmodule : lhr_regulator
`default_nettype wire

// ### logic/lhr_timing.sv
`timescale 1ns/100ps
`default_nettype none
module lhr_timing #(
   parameter int LEAD_CYC = lhr_pkg::HOLD_LEAD_CYC
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Link
   lhr_link_if.timing link,
   // User side
   input  wire logic negLogic,
   input  wire logic holdCmd,
   output logic      gradGo,
   output logic      busy
);
   if (LEAD_CYC < 1)
   begin : g_badLead
      $error("LEAD_CYC must be positive");
   end

   typedef enum logic [2:0] {
      LT_IDLE = 3'b001,
      LT_LEAD = 3'b010,
      LT_HOLD = 3'b100
   } lhr_state_t;

   lhr_state_t  state_r;
   logic [31:0] cnt_r;
   logic        hold_r;

   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
      begin
         state_r <= LT_IDLE;
         cnt_r   <= '0;
         hold_r  <= 1'b0;
         gradGo  <= 1'b0;
      end
      else
         case (state_r)
            LT_IDLE:
               if (cnt_r != 0)
                  cnt_r <= cnt_r - 32'd1;
               else if (holdCmd)
               begin
                  hold_r  <= 1'b1;
                  cnt_r   <= 32'(LEAD_CYC);
                  state_r <= LT_LEAD;
               end
            LT_LEAD:
               if (cnt_r != 0)
                  cnt_r <= cnt_r - 32'd1;
               else
               begin
                  gradGo  <= 1'b1;
                  state_r <= LT_HOLD;
               end
            LT_HOLD:
               if (!holdCmd)
               begin
                  gradGo  <= 1'b0;
                  hold_r  <= 1'b0;
                  cnt_r   <= 32'(LEAD_CYC);
                  state_r <= LT_IDLE;
               end
            default:
               state_r <= LT_IDLE;
         endcase

   logic pin_r;
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         pin_r <= 1'b0;
      else
         pin_r <= hold_r ^ negLogic;
   assign link.holdReq = pin_r;

   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b)
         busy <= 1'b0;
      else
         busy <= (state_r != LT_IDLE) || cnt_r != 0;
endmodule : lhr_timing
`default_nettype wire

// ### bench/lhr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module lhr_checker #(
   parameter int LEAD_CYC = 10
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Link
   input  wire logic        holdReq,
   input  wire logic        readyLed,
   // Timing end
   input  wire logic        negLogic,
   input  wire logic        gradGo,
   input  wire logic        busy,
   // Regulator end
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbAck,
   input  wire logic [15:0] regOut
);
   // ------------------------------------------------------------------
   // Hold level as seen on the wire
   // ------------------------------------------------------------------
   logic act;
   assign act = holdReq ^ negLogic;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   ack_resp_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("Bus request not answered after one cycle");
   ack_one_a: assert property (wbAck |=> !wbAck)
      else $error("Bus answer longer than one cycle");
   ready_drop_a: assert property (act [*5] |-> !readyLed)
      else $error("Ready indicator on during hold");
   ready_back_a: assert property (!act [*8] |-> readyLed)
      else $error("Ready indicator not restored");
   out_freeze_a: assert property (act [*5] |=> $stable(regOut))
      else $error("Regulator output moved during hold");
   grad_lead_a: assert property ($rose(gradGo) |-> act && $past(act, LEAD_CYC))
      else $error("Gradient allowed before hold lead time");
   hold_gap_a: assert property ($fell(act) |-> !act [*8])
      else $error("Hold reasserted within recovery time");
   busy_hold_a: assert property (act && $past(act) |-> busy)
      else $error("Timing end idle while hold active");
endmodule : lhr_checker
`default_nettype wire

// ### bench/lock_hold_regulator_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lock_hold_regulator_control_tb_top;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   typedef struct packed {logic [31:0] exp; logic [31:0] msk;} lhr_note_t;
   logic        clk_sys, rst_b, wbCyc, wbStb, wbWe, wbAck, negLogic, holdCmd, gradGo, busy;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatW, wbDatR, rndState, q1, q2;
   logic [15:0] lockErr, regOut, v;
   logic [15:0] pv [5][3];
   logic [7:0]  pa [3];
   int          err_total, checks;
   lhr_note_t   notes [$];
   lhr_note_t   nt;
   lhr_link_if  i_lhr_link_if ();
   lhr_regulator #(.RELOCK_CYC(20)) i_lhr_regulator (.clk_sys(clk_sys), .rst_b(rst_b),
      .link(i_lhr_link_if), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .lockErr(lockErr),
      .regOut(regOut));
   lhr_timing #(.LEAD_CYC(10)) i_lhr_timing (.clk_sys(clk_sys), .rst_b(rst_b),
      .link(i_lhr_link_if), .negLogic(negLogic), .holdCmd(holdCmd), .gradGo(gradGo),
      .busy(busy));
   lhr_checker #(.LEAD_CYC(10)) i_lhr_checker (.clk_sys(clk_sys), .rst_b(rst_b),
      .holdReq(i_lhr_link_if.holdReq), .readyLed(i_lhr_link_if.readyLed),
      .negLogic(negLogic), .gradGo(gradGo), .busy(busy), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbAck(wbAck), .regOut(regOut));
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("Counts: %0d compared, %0d mismatched", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic timed_out();
      err_total++;
      $display("[FAIL] t=%0t wait ran out", $time);
      complete_run();
   endtask : timed_out
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      rndState = xs(rndState);
      lockErr <= rndState[15:0];
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatW <= d;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk_sys);
         if (wbAck === 1'b1)
            break;
      end
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk_sys);
      if (n == 20)
         timed_out();
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     output logic [31:0] q);
      notes.push_back('{exp: e, msk: m});
      bus(1'b0, a, 32'h0000_0000, q);
   endtask : rd
   task automatic rdSet(input int i);
      logic [31:0] q;
      for (int j = 0; j < 3; j++)
         rd(pa[j], {16'h0000, pv[i][j]}, 32'h0000_ffff, q);
   endtask : rdSet
   task automatic waitOn(input logic onBusy, input logic val);
      int n;
      for (n = 0; n < 200; n++)
      begin
         @(posedge clk_sys);
         if ((onBusy ? busy : gradGo) === val)
            break;
      end
      if (n == 200)
         timed_out();
   endtask : waitOn
   // ------------------------------------------------------------------
   // Read monitor
   // ------------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      if (wbAck === 1'b1 && wbWe === 1'b0)
      begin
         nt = (notes.size() > 0) ? notes.pop_front()
                                 : lhr_note_t'{exp: 32'h0000_0001, msk: 32'h0000_0000};
         check(wbDatR & nt.msk, nt.exp);
      end
   end
   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial
   begin
      {wbCyc, wbStb, wbWe, negLogic, holdCmd, rst_b} = '0;
      {wbAdr, wbSel, wbDatW, lockErr, err_total, checks} = '0;
      rndState = 32'h0000_b6fa;
      pa = '{lhr_pkg::ADR_FILT, lhr_pkg::ADR_GAIN, lhr_pkg::ADR_TIME};
      pv = '{'{lhr_pkg::DEF_FILT, lhr_pkg::DEF_GAIN, lhr_pkg::DEF_TIME},
             '{lhr_pkg::ANA_FILT, lhr_pkg::DEF_GAIN, lhr_pkg::DEF_TIME},
             '{lhr_pkg::HB1_FILT, lhr_pkg::HB1_GAIN, lhr_pkg::HB1_TIME},
             '{lhr_pkg::HB2_FILT, lhr_pkg::HB2_GAIN, lhr_pkg::HB2_TIME},
             '{lhr_pkg::HB3_FILT, lhr_pkg::HB3_GAIN, lhr_pkg::HB3_TIME}};
      wbSel = 4'hf;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdSet(0);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0002, 32'h0000_001f, q1);
      wr(8'h30, 32'h0000_0001);
      rd(8'h30, 32'h0000_0000, 32'hffff_ffff, q1);
      wr(lhr_pkg::ADR_TIME, 32'h0000_0001);
      rdSet(0);
      $display("test reset done");
      for (int i = 0; i < 5; i++)
      begin
         wr(lhr_pkg::ADR_CTRL, 32'h0000_0080 | (i << 4));
         rdSet(i);
      end
      wbSel <= 4'he;
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0090);
      wbSel <= 4'hf;
      rdSet(4);
      $display("test presets done");
      rndState = xs(rndState);
      v = {5'h00, rndState[10:0]};
      wr(lhr_pkg::ADR_EDIT, {16'h0000, v});
      wr(lhr_pkg::ADR_EDIT, 32'h0002_0000);
      rd(lhr_pkg::ADR_FILT, 32'h0000_07d0, 32'h0000_ffff, q1);
      wr(lhr_pkg::ADR_EDIT, {16'h0000, v});
      wr(lhr_pkg::ADR_EDIT, 32'h0001_0000);
      rd(lhr_pkg::ADR_FILT, {16'h0000, v}, 32'h0000_ffff, q1);
      wr(lhr_pkg::ADR_EDIT, 32'h0000_001e);
      wr(lhr_pkg::ADR_EDIT, 32'h0001_0000);
      rd(lhr_pkg::ADR_FILT, 32'h0000_001e, 32'h0000_ffff, q1);
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0001);
      wr(lhr_pkg::ADR_EDIT, 32'h0000_0014);
      wr(lhr_pkg::ADR_EDIT, 32'h0001_0000);
      rd(lhr_pkg::ADR_FILT, 32'h0000_0014, 32'h0000_ffff, q1);
      $display("test edit done");
      v = {8'h00, rndState[18:11]} | 16'h0001;
      wr(lhr_pkg::ADR_EDIT, {16'h000c, v});
      wr(lhr_pkg::ADR_EDIT, 32'h0001_0000);
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0000);
      rd(lhr_pkg::ADR_DRIFT, {16'h0000, v}, 32'h0000_ffff, q1);
      rd(lhr_pkg::ADR_OUT, 32'h0000_0000, 32'h0000_0000, q1);
      rd(lhr_pkg::ADR_OUT, 32'h0000_0000, 32'h0000_0000, q2);
      check({16'h0000, q2[15:0] - q1[15:0]}, {16'h0000, 16'(3 * v)});
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0002);
      rd(lhr_pkg::ADR_OUT, 32'h0000_0000, 32'h0000_0000, q1);
      rd(lhr_pkg::ADR_OUT, 32'h0000_0000, 32'h0000_0000, q2);
      check({16'h0000, q2[15:0] - q1[15:0]}, 32'h0000_0000);
      $display("test drift done");
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0001);
      holdCmd <= 1'b1;
      waitOn(1'b0, 1'b1);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0005, 32'h0000_0007, q1);
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0005);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0009, 32'h0000_000b, q1);
      rd(lhr_pkg::ADR_OUT, 32'h0000_0000, 32'h0000_0000, q1);
      rd(lhr_pkg::ADR_OUT, 32'h0000_0000, 32'h0000_0000, q2);
      check({16'h0000, q2[15:0]}, {16'h0000, q1[15:0]});
      holdCmd <= 1'b0;
      @(posedge clk_sys);
      holdCmd <= 1'b1;
      waitOn(1'b0, 1'b1);
      holdCmd <= 1'b0;
      waitOn(1'b1, 1'b0);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0006, 32'h0000_0007, q1);
      repeat (30) @(posedge clk_sys);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0002, 32'h0000_0007, q1);
      $display("test hold done");
      negLogic <= 1'b1;
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0005);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0000, 32'h0000_0008, q1);
      repeat (30) @(posedge clk_sys);
      holdCmd <= 1'b1;
      waitOn(1'b0, 1'b1);
      check({31'h0000_0000, i_lhr_link_if.holdReq}, 32'h0000_0000);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0001, 32'h0000_0003, q1);
      rd(lhr_pkg::ADR_OUT, 32'h0000_0000, 32'h0000_0000, q1);
      wr(lhr_pkg::ADR_CTRL, 32'h0000_0006);
      holdCmd <= 1'b0;
      waitOn(1'b1, 1'b0);
      repeat (30) @(posedge clk_sys);
      rd(lhr_pkg::ADR_STAT, 32'h0000_0002, 32'h0000_0007, q2);
      rd(lhr_pkg::ADR_OUT, {16'h0000, q1[15:0]}, 32'h0000_ffff, q2);
      $display("test polarity done");
      complete_run();
   end
endmodule : lock_hold_regulator_control_tb_top
`default_nettype wire
